// [logic/edge_delay_timer.sv]
// Millisecond delay counter for one enable edge
`timescale 1ns/1ps
`include "load_switch_consts.svh"

module edge_delay_timer #(
	parameter int MS_WIDTH = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Millisecond tick and control
	input wire logic tick,
	input wire logic start,
	input wire logic [MS_WIDTH-1:0] lengthMs,
	// Completion
	output logic done
);

	logic [MS_WIDTH-1:0] count_reg;
	logic running_reg;

	initial begin
		if (MS_WIDTH < 7) $error("edge_delay_timer needs at least 7 bits for 64 ms");
	end

	// Count down whole ticks; first tick may be partial, up to one tick short, beyond the ten percent of [RULE_09] at 2 to 8 ms
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			running_reg <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_reg <= lengthMs;
				running_reg <= 1'b1;
			end else if (running_reg && tick) begin
				if (count_reg <= MS_WIDTH'(1)) begin
					running_reg <= 1'b0;
					done <= 1'b1;
				end
				count_reg <= count_reg - MS_WIDTH'(1);
			end
		end
	end

endmodule

// [logic/load_switch_consts.svh]
// Constants for the load switch A enable sequencer: offsets, fields, resets, timing
// Summary of operation
// [RULE_01] Mask register one: bit 0 includes a rail's power good, bit 1 excludes it.
// [RULE_02] Source register bit1 masks switch B2/aux reg 1 good, bit0 masks switch B1.
// [RULE_03] Switch on only with source active and all unmasked power goods high.
// [RULE_04] Source field 4:2 picks control input 1,2,5,4,3, 3 and 4, or 6.
// [RULE_05] Source code 111 feeds a constant one, no pin needed.
// [RULE_06] Delay register bit 6 picks control input 3 or 6 for termination enable.
// [RULE_07] Fall delay field 5:3: none, 2, 4, 8, 16, 24, 32, 64 ms.
// [RULE_08] Rise delay field 2:0 uses the same eight-step millisecond code.
// [RULE_09] Delays may deviate up to ten percent; checks must allow that. The timer runs up to one tick short, over ten percent at 2 to 8 ms.
// [RULE_10] Good level field 6:5 selects 1.5, 1.8, 2.5 or 3.3 V.
`ifndef LOAD_SWITCH_CONSTS_SVH
`define LOAD_SWITCH_CONSTS_SVH

// ********************************************************************
// Register byte addresses (printed offsets are register indexes)
// ********************************************************************
`define IDX_MASK_ONE 8'h19
`define IDX_SOURCE_SEL 8'h1a
`define IDX_EDGE_DELAYS 8'h1b
`define ADDR_MASK_ONE 12'h064
`define ADDR_SOURCE_SEL 12'h068
`define ADDR_EDGE_DELAYS 12'h06c
`define ADDR_STATUS 12'h070

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define MASK_LOAD_SWITCH_B1_BIT 0
`define MASK_SWB2_BIT 1
`define SRC_SEL_LSB 2
`define GOOD_LVL_LSB 5
`define TERM_SEL_BIT 6
`define RISE_DLY_LSB 0
`define FALL_DLY_LSB 3
`define RESET_MASK_ONE 8'h00
`define RESET_SOURCE_SEL 8'h00
`define RESET_EDGE_DELAYS 8'h00

// ********************************************************************
// Timing: one millisecond tick at 250 MHz
// ********************************************************************
`define CLK_MHZ 250
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)

`endif

// [logic/load_switch_pkg.sv]
// Types shared by the load switch A enable sequencer
package load_switch_pkg;

	// Power-good inputs from the other rails
	typedef struct packed {
		logic [7:0] rails;
		logic switchB2AuxReg1;
		logic switchB1;
	} power_good_t;

	// Selectable control input pins, index 0 is control input 1
	typedef logic [5:0] control_inputs_t;

	// Enable source codes
	typedef enum logic [2:0] {
		SRC_IN1 = 3'h0,
		SRC_IN2 = 3'h1,
		SRC_IN5 = 3'h2,
		SRC_IN4 = 3'h3,
		SRC_IN3 = 3'h4,
		SRC_IN3_AND_4 = 3'h5,
		SRC_IN6 = 3'h6,
		SRC_ALWAYS = 3'h7
	} enable_source_t;

	// Edge delay sequencer states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_RISE_WAIT,
		ST_ON,
		ST_FALL_WAIT
	} seq_state_t;

endpackage

// [logic/load_switch_sequencer.sv]
// Load switch A enable sequencer with APB register slave
`timescale 1ns/1ps
`include "load_switch_consts.svh"

module load_switch_sequencer #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Control input pins and power-good states
	input wire load_switch_pkg::control_inputs_t controlInputs,
	input wire load_switch_pkg::power_good_t powerGood,
	// Switch and regulator controls
	output logic loadSwitchAEnable,
	output logic terminationEnable,
	output logic [1:0] switchAGoodLevel
);

	// ********************************************************************
	// Registers and local signals
	// ********************************************************************
	logic [7:0] maskOne_reg;
	logic [7:0] sourceSel_reg;
	logic [7:0] edgeDelays_reg;
	logic [31:0] tickCount_reg;
	logic tick_reg;
	logic request;
	logic srcActive;
	logic goodAll;
	logic condition;
	logic timerStart;
	logic [6:0] timerLength;
	logic timerDone;
	logic apbWrite;
	logic apbRead;
	logic [31:0] readMux;
	logic addrOk;
	load_switch_pkg::seq_state_t state_reg;
	load_switch_pkg::seq_state_t state_next;
	load_switch_pkg::enable_source_t source;

	initial begin
		if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
	end

	// Delay code to milliseconds
	function automatic logic [6:0] delay_ms(input logic [2:0] code);
		logic [6:0] ms;
		ms = 7'h00;
		unique case (code)
			3'h0: ms = 7'h00;
			3'h1: ms = 7'h02;
			3'h2: ms = 7'h04;
			3'h3: ms = 7'h08;
			3'h4: ms = 7'h10;
			3'h5: ms = 7'h18;
			3'h6: ms = 7'h20;
			3'h7: ms = 7'h40;
		endcase
		return ms;
	endfunction

	// ********************************************************************
	// APB register slave
	// ********************************************************************
	// Zero-wait slave: every access ends in its first access cycle
	assign apbWrite = psel && penable && pwrite;
	assign apbRead = psel && penable && !pwrite;
	assign addrOk = (paddr == `ADDR_MASK_ONE) || (paddr == `ADDR_SOURCE_SEL) ||
		(paddr == `ADDR_EDGE_DELAYS) || (paddr == `ADDR_STATUS);

	// Mask register one, bit per rail [RULE_01]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			maskOne_reg <= `RESET_MASK_ONE;
		end else if (apbWrite && paddr == `ADDR_MASK_ONE && pstrb[0]) begin
			maskOne_reg <= pwdata[7:0];
		end
	end

	// Source select, masks and good level; bit 7 reserved, reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sourceSel_reg <= `RESET_SOURCE_SEL;
		end else if (apbWrite && paddr == `ADDR_SOURCE_SEL && pstrb[0]) begin
			sourceSel_reg <= {1'b0, pwdata[6:0]};
		end
	end

	// Edge delays and termination source; bit 7 reserved, reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			edgeDelays_reg <= `RESET_EDGE_DELAYS;
		end else if (apbWrite && paddr == `ADDR_EDGE_DELAYS && pstrb[0]) begin
			edgeDelays_reg <= {1'b0, pwdata[6:0]};
		end
	end

	// Read mux; status shows live condition, request and sequencer state
	always_comb begin
		readMux = 32'h0000_0000;
		unique case (paddr)
			`ADDR_MASK_ONE: readMux = {24'h000000, maskOne_reg};
			`ADDR_SOURCE_SEL: readMux = {24'h000000, sourceSel_reg};
			`ADDR_EDGE_DELAYS: readMux = {24'h000000, edgeDelays_reg};
			`ADDR_STATUS: readMux = {26'h0000000, state_reg, terminationEnable, loadSwitchAEnable,
				condition, srcActive};
			default: readMux = 32'h0000_0000;
		endcase
	end

	// Answer in the access phase; unmapped addresses raise pslverr
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addrOk;
			if (psel && !penable && !pwrite) begin
				prdata <= readMux;
			end
		end
	end

	// ********************************************************************
	// Enable condition
	// ********************************************************************
	assign source = load_switch_pkg::enable_source_t'(sourceSel_reg[`SRC_SEL_LSB +: 3]);

	// Source multiplexer [RULE_04]
	always_comb begin
		srcActive = 1'b0;
		unique case (source)
			load_switch_pkg::SRC_IN1: srcActive = controlInputs[0];
			load_switch_pkg::SRC_IN2: srcActive = controlInputs[1];
			load_switch_pkg::SRC_IN5: srcActive = controlInputs[4];
			load_switch_pkg::SRC_IN4: srcActive = controlInputs[3];
			load_switch_pkg::SRC_IN3: srcActive = controlInputs[2];
			load_switch_pkg::SRC_IN3_AND_4: srcActive = controlInputs[2] && controlInputs[3];
			load_switch_pkg::SRC_IN6: srcActive = controlInputs[5];
			load_switch_pkg::SRC_ALWAYS: srcActive = 1'b1; // [RULE_05]
		endcase
	end

	// A mask bit of one forces that power good true
	assign goodAll = &(powerGood.rails | maskOne_reg) && // [RULE_01]
		(powerGood.switchB1 || sourceSel_reg[`MASK_LOAD_SWITCH_B1_BIT]) && // [RULE_02]
		(powerGood.switchB2AuxReg1 || sourceSel_reg[`MASK_SWB2_BIT]); // [RULE_02]
	assign condition = srcActive && goodAll; // [RULE_03]

	// ********************************************************************
	// Millisecond timebase
	// ********************************************************************
	// Free-running divider, one-cycle tick each millisecond
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickCount_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else if (tickCount_reg == 32'(TICK_CYCLES - 1)) begin
			tickCount_reg <= 32'h0000_0000;
			tick_reg <= 1'b1;
		end else begin
			tickCount_reg <= tickCount_reg + 32'h0000_0001;
			tick_reg <= 1'b0;
		end
	end

	// ********************************************************************
	// Edge delay sequencer
	// ********************************************************************
	assign request = condition;

	// Next state; an edge that reverses mid-wait abandons the wait
	always_comb begin
		state_next = state_reg;
		timerStart = 1'b0;
		timerLength = 7'h00;
		unique case (state_reg)
			load_switch_pkg::ST_OFF: begin
				if (request) begin
					timerLength = delay_ms(edgeDelays_reg[`RISE_DLY_LSB +: 3]); // [RULE_08]
					if (timerLength == 7'h00) begin
						state_next = load_switch_pkg::ST_ON;
					end else begin
						timerStart = 1'b1;
						state_next = load_switch_pkg::ST_RISE_WAIT;
					end
				end
			end
			load_switch_pkg::ST_RISE_WAIT: begin
				if (!request) begin
					state_next = load_switch_pkg::ST_OFF;
				end else if (timerDone) begin
					state_next = load_switch_pkg::ST_ON; // [RULE_08]
				end
			end
			load_switch_pkg::ST_ON: begin
				if (!request) begin
					timerLength = delay_ms(edgeDelays_reg[`FALL_DLY_LSB +: 3]); // [RULE_07]
					if (timerLength == 7'h00) begin
						state_next = load_switch_pkg::ST_OFF;
					end else begin
						timerStart = 1'b1;
						state_next = load_switch_pkg::ST_FALL_WAIT;
					end
				end
			end
			load_switch_pkg::ST_FALL_WAIT: begin
				if (request) begin
					state_next = load_switch_pkg::ST_ON;
				end else if (timerDone) begin
					state_next = load_switch_pkg::ST_OFF; // [RULE_07] [RULE_03]
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= load_switch_pkg::ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	edge_delay_timer #(
		.MS_WIDTH(7)
	) delayTimer (
		.clk(clk),
		.rst(rst),
		.tick(tick_reg),
		.start(timerStart),
		.lengthMs(timerLength),
		.done(timerDone)
	);

	// ********************************************************************
	// Registered outputs
	// ********************************************************************
	// Switch is on in ST_ON and while the fall delay runs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loadSwitchAEnable <= 1'b0;
		end else begin
			loadSwitchAEnable <= (state_next == load_switch_pkg::ST_ON) ||
				(state_next == load_switch_pkg::ST_FALL_WAIT); // [RULE_03]
		end
	end

	// Termination regulator source pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			terminationEnable <= 1'b0;
		end else begin
			terminationEnable <= edgeDelays_reg[`TERM_SEL_BIT] ? controlInputs[5] : controlInputs[2]; // [RULE_06]
		end
	end

	// Good level code passed to the analog comparator
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			switchAGoodLevel <= 2'h0;
		end else begin
			switchAGoodLevel <= sourceSel_reg[`GOOD_LVL_LSB +: 2]; // [RULE_10]
		end
	end

endmodule

// [verif/control_host_model.sv]
// Host logic model driving the six control input pins
`timescale 1ns/1ps
module control_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin levels requested by the bench
	input wire logic [5:0] pinsWanted,
	// Pins toward the sequencer
	output load_switch_pkg::control_inputs_t controlInputs
);
	// Pins move only after an edge, like real synchronous host logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			controlInputs <= 6'h00;
		end else begin
			controlInputs <= pinsWanted;
		end
	end
endmodule

// [verif/load_switch_sequencer_assertions.sv]
// Port-level checks for the load switch A sequencer
`timescale 1ns/1ps
module load_switch_sequencer_assertions #(
	parameter int TICK_CYCLES = 25
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and outputs
	input wire load_switch_pkg::control_inputs_t controlInputs,
	input wire load_switch_pkg::power_good_t powerGood,
	input wire logic loadSwitchAEnable,
	input wire logic terminationEnable,
	input wire logic [1:0] switchAGoodLevel
);
	logic [7:0] maskOne;
	logic [7:0] srcReg;
	logic [7:0] dlyReg;
	logic wrHit;
	logic srcOn;
	logic cond;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	assign wrHit = psel && penable && pwrite && pready && pstrb[0];
	// Shadow registers, so the checks need no view of the bodies
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			maskOne <= 8'h00;
			srcReg <= 8'h00;
			dlyReg <= 8'h00;
		end else if (wrHit) begin
			if (paddr == 12'h064) maskOne <= pwdata[7:0];
			if (paddr == 12'h068) srcReg <= pwdata[7:0];
			if (paddr == 12'h06c) dlyReg <= pwdata[7:0];
		end
	end
	// Expected enable source and combined condition
	always_comb begin
		case (srcReg[4:2])
			3'h0: srcOn = controlInputs[0];
			3'h1: srcOn = controlInputs[1];
			3'h2: srcOn = controlInputs[4];
			3'h3: srcOn = controlInputs[3];
			3'h4: srcOn = controlInputs[2];
			3'h5: srcOn = controlInputs[2] && controlInputs[3];
			3'h6: srcOn = controlInputs[5];
			default: srcOn = 1'b1;
		endcase
	end
	assign cond = srcOn && (&(powerGood.rails | maskOne)) && (powerGood.switchB1 | srcReg[0])
		&& (powerGood.switchB2AuxReg1 | srcReg[1]);
	sequence apbSetup;
		psel && !penable;
	endsequence
	a_access_ready: assert property (apbSetup |=> pready)
		else $error("no ready in access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_unmapped_error: assert property ((apbSetup and !(paddr inside {12'h064, 12'h068, 12'h06c, 12'h070}))
		|=> pslverr)
		else $error("unmapped access without error");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_level_copy: assert property (wrHit && paddr == 12'h068 |=> ##1 switchAGoodLevel == srcReg[6:5])
		else $error("good level not following register");
	a_term_source: assert property (!$past(rst) |-> terminationEnable ==
		$past(dlyReg[6] ? controlInputs[5] : controlInputs[2]))
		else $error("termination enable wrong pin");
	a_rise_prompt: assert property ($rose(cond) && dlyReg[2:0] == 3'h0 |-> ##[1:2] loadSwitchAEnable)
		else $error("undelayed rise late");
	a_fall_prompt: assert property ($fell(cond) && dlyReg[5:3] == 3'h0 |-> ##[1:2] !loadSwitchAEnable)
		else $error("undelayed fall late");
	a_rise_cause: assert property ($rose(loadSwitchAEnable) |-> $past(cond) || $past(cond, 2))
		else $error("switch on without condition");
endmodule
bind load_switch_sequencer load_switch_sequencer_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .controlInputs(controlInputs), .powerGood(powerGood),
	.loadSwitchAEnable(loadSwitchAEnable), .terminationEnable(terminationEnable),
	.switchAGoodLevel(switchAGoodLevel));

// [verif/tb_load_switch_enable_sequencer.sv]
// Self-checking bench for the load switch A sequencer
`timescale 1ns/1ps
module tb_load_switch_enable_sequencer;
	localparam int T = 25;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, en, term, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb;
	logic [5:0] pins;
	logic [1:0] lvl;
	load_switch_pkg::control_inputs_t ci;
	load_switch_pkg::power_good_t pg;
	int n_fail, checks, cyc, n;
	// Short tick keeps the millisecond delays cheap
	load_switch_sequencer #(.TICK_CYCLES(T)) u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .controlInputs(ci), .powerGood(pg), .loadSwitchAEnable(en),
		.terminationEnable(term), .switchAGoodLevel(lvl));
	control_host_model u_host (.clk(clk), .rst(rst), .pinsWanted(pins), .controlInputs(ci));
	task test_done;
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until ready is seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so the next setup never re-drives psel in this step
		@(posedge clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask
	task pause;
		repeat (6) @(posedge clk);
	endtask
	task waitEn(input logic x, input int lim);
		n = 0;
		while (en !== x && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(en, x);
	endtask
	// Delays may run short by a partial first tick and by the tolerance
	task span(input int m, input int ms);
		checks++;
		if (m < ms * T * 9 / 10 - T || m > ms * T * 11 / 10 + 6) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, m, ms * T);
		end
	endtask
	task t_regs;
		apb(1'b0, 12'h064, 32'h0, 4'hf);
		chk(r, 32'h0);
		wr(12'h068, 32'hffff_ffff);
		apb(1'b1, 12'h068, 32'h0, 4'h0);
		apb(1'b0, 12'h068, 32'h0, 4'hf);
		chk(r, 32'h7f);
		apb(1'b0, 12'h0a0, 32'h0, 4'hf);
		chk({r[30:0], e}, 32'h1);
		for (int c = 0; c < 4; c++) begin
			wr(12'h068, 32'(c << 5));
			pause;
			chk(lvl, 32'(c));
		end
	endtask
	task t_source;
		logic [5:0] sel [8];
		sel = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00};
		for (int c = 0; c < 8; c++) begin
			pins <= ~sel[c];
			wr(12'h068, 32'(c << 2));
			pause;
			chk(en, 32'(c == 7));
			pins <= sel[c];
			pause;
			chk(en, 32'h1);
		end
		pins <= 6'h04;
		wr(12'h068, 32'h14);
		pause;
		chk(en, 32'h0);
		// Status: source and condition low, switch off, termination on
		apb(1'b0, 12'h070, 32'h0, 4'hf);
		chk(r, 32'h8);
	endtask
	task t_mask;
		for (int j = 0; j < 10; j++) begin
			pg <= ~(10'h1 << j);
			wr(12'h068, 32'h1c);
			wr(12'h064, 32'h0);
			pause;
			chk(en, 32'h0);
			if (j < 2) wr(12'h068, 32'h1c | (32'h1 << j));
			else wr(12'h064, 32'h1 << (j - 2));
			pause;
			chk(en, 32'h1);
		end
		pg <= '1;
		wr(12'h064, 32'h0);
		wr(12'h068, 32'h0);
		pause;
	endtask
	task t_delay;
		int d [8];
		d = '{0, 2, 4, 8, 16, 24, 32, 64};
		for (int k = 0; k < 8; k++) begin
			wr(12'h06c, 32'(k * 9));
			pins <= 6'h01;
			waitEn(1'b1, d[k] * T * 2 + 9);
			span(n, d[k]);
			pins <= 6'h00;
			waitEn(1'b0, d[k] * T * 2 + 9);
			span(n, d[k]);
		end
	endtask
	// A short pulse during the rise wait must not switch on
	task t_glitch;
		// Long fall delay, so a wrongly completed rise would still show
		wr(12'h06c, 32'h3a);
		pins <= 6'h01;
		repeat (T) @(posedge clk);
		pins <= 6'h00;
		repeat (6 * T) @(posedge clk);
		chk(en, 32'h0);
	endtask
	task t_term;
		for (int s = 0; s < 2; s++) begin
			wr(12'h06c, 32'(s << 6));
			pins <= s ? 6'h04 : 6'h20;
			pause;
			chk(term, 32'h0);
			pins <= s ? 6'h20 : 6'h04;
			pause;
			chk(term, 32'h1);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, pstrb, pins} = '0;
		pg = '1;
		n_fail = 0;
		checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_source;
		t_mask;
		t_delay;
		t_glitch;
		t_term;
		test_done;
	end
	// Hang guard, well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			test_done;
		end
	end
endmodule
